// ==== src/pbc_pkg.sv ====
// package for the basic PHY control register block
// shared constants, field positions, reset values and carrier types
package pbc_pkg;

   // register index of the basic control register on the management port
   localparam logic [4:0] PBC_REG_INDEX = 5'h00;

   // field positions inside the 16-bit register
   localparam int PBC_BIT_SOFT_RESET = 15;
   localparam int PBC_BIT_LOOPBACK = 14;
   localparam int PBC_BIT_SPEED_LSB = 13;
   localparam int PBC_BIT_NEG_EN = 12;
   localparam int PBC_BIT_STANDBY = 11;
   localparam int PBC_BIT_ISOLATE = 10;
   localparam int PBC_BIT_NEG_RESTART = 9;
   localparam int PBC_BIT_DUPLEX = 8;
   localparam int PBC_BIT_COL_TEST = 7;
   localparam int PBC_BIT_SPEED_MSB = 6;
   localparam int PBC_BIT_ONE_WAY = 5;

   // reset and fixed values
   localparam logic PBC_RST_LOOPBACK = 1'b0;
   localparam logic PBC_RST_ONE_WAY = 1'b0;
   localparam logic PBC_FIX_NEG_EN = 1'b0;
   localparam logic PBC_FIX_NEG_RESTART = 1'b0;
   localparam logic PBC_FIX_DUPLEX = 1'b1;
   localparam logic PBC_FIX_COL_TEST = 1'b0;
   localparam logic [1:0] PBC_SPEED_100 = 2'h1;
   localparam logic [3:0] PBC_OP_STATE_NORMAL = 4'h3;

   // soft reset pulse length
   localparam int PBC_CLK_PERIOD_NS = 40;
   localparam int PBC_SOFT_RESET_NS = 1000;
   localparam int PBC_SOFT_RESET_CYCLES = (PBC_SOFT_RESET_NS + PBC_CLK_PERIOD_NS - 1) / PBC_CLK_PERIOD_NS;

   // power and isolation modes, one-hot
   typedef enum logic [2:0] {
      PBC_MODE_NORMAL = 3'h1,
      PBC_MODE_STANDBY = 3'h2,
      PBC_MODE_ISOLATED = 3'h4
   } pbc_mode_e;

   // register read or write request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } pbc_req_s;

   // controls driven into the PHY core
   typedef struct packed {
      logic loopback;
      logic [1:0] loop_path;
      logic standby;
      logic isolate;
      logic tx_enable;
   } pbc_ctrl_s;

endpackage : pbc_pkg

// ==== src/pbc_reset_pulse.sv ====
// soft reset pulse generator for the basic PHY control block
// assumes a single start strobe; ignores restarts while a pulse runs
`timescale 1ns/1ps
module pbc_reset_pulse
   import pbc_pkg::*;
#(
   parameter int CYCLES = PBC_SOFT_RESET_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic start_i,
   output logic busy_o
);

   typedef struct packed {
      logic busy;
      logic [15:0] cnt;
   } pbc_pulse_s;

   pbc_pulse_s state_q, state_d;

   initial begin
      if (CYCLES < 1 || CYCLES > 65535) $error("pbc_reset_pulse: CYCLES out of range");
   end

   // count down while busy, the last cycle drops busy
   always_comb begin
      state_d = state_q;
      if (state_q.busy) begin
         if (state_q.cnt == 16'h0001) begin
            state_d.busy = 1'b0;
         end
         state_d.cnt = state_q.cnt - 16'h0001;
      end else if (start_i) begin
         state_d.busy = 1'b1;
         state_d.cnt = 16'(CYCLES);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         state_q <= '0;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   assign busy_o = state_q.busy;

endmodule : pbc_reset_pulse

// ==== src/pbc_mode_ctrl.sv ====
// standby / isolation mode controller with conflict detection
// writes are judged against the mode held before the write
`timescale 1ns/1ps
module pbc_mode_ctrl
   import pbc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic clear_i,
   input wire logic wr_i,
   input wire logic standby_wr_i,
   input wire logic isolate_wr_i,
   input wire logic [3:0] op_state_i,
   output logic standby_o,
   output logic isolate_o,
   output logic conflict_o,
   output logic normal_req_o
);

   typedef struct packed {
      pbc_mode_e mode;
      logic conflict;
      logic normal_req;
   } pbc_modectl_s;

   pbc_modectl_s state_q, state_d;

   // mode transitions; pulses last one enabled cycle
   always_comb begin
      state_d = state_q;
      state_d.conflict = 1'b0;
      state_d.normal_req = 1'b0;
      if (clear_i) begin
         state_d.mode = PBC_MODE_NORMAL;
      end else if (wr_i) begin
         case (state_q.mode)
            PBC_MODE_NORMAL: begin
               // standby wins a simultaneous request; isolation then refused
               if (standby_wr_i) begin
                  state_d.mode = PBC_MODE_STANDBY;
                  state_d.conflict = isolate_wr_i;
               end else if (isolate_wr_i) begin
                  state_d.mode = PBC_MODE_ISOLATED;
               end
            end
            PBC_MODE_STANDBY: begin
               state_d.conflict = isolate_wr_i;
               if (!standby_wr_i) begin
                  state_d.mode = PBC_MODE_NORMAL;
                  state_d.normal_req = (op_state_i == PBC_OP_STATE_NORMAL);
               end
            end
            PBC_MODE_ISOLATED: begin
               state_d.conflict = standby_wr_i;
               if (!isolate_wr_i) begin
                  state_d.mode = PBC_MODE_NORMAL;
               end
            end
            default: begin
               state_d.mode = PBC_MODE_NORMAL;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         state_q <= '{mode: PBC_MODE_NORMAL, conflict: 1'b0, normal_req: 1'b0};
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   assign standby_o = (state_q.mode == PBC_MODE_STANDBY);
   assign isolate_o = (state_q.mode == PBC_MODE_ISOLATED);
   assign conflict_o = state_q.conflict & ce_i;
   assign normal_req_o = state_q.normal_req & ce_i;

endmodule : pbc_mode_ctrl

// ==== src/pbc_ctrl_reg.sv ====
// basic control register of a single-pair 100 Mbit/s PHY
// assumes a management front end that presents decoded read and write strobes
// with register index and data, synchronous to core_clk_i
`timescale 1ns/1ps
module pbc_ctrl_reg
   import pbc_pkg::*;
#(
   parameter int RESET_CYCLES = PBC_SOFT_RESET_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire pbc_req_s req_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   input wire logic [3:0] op_state_i,
   input wire logic [1:0] loop_path_i,
   input wire logic link_valid_i,
   output logic phy_reset_o,
   output logic control_conflict_o,
   output logic normal_req_o,
   output pbc_ctrl_s ctrl_o
);

   initial begin
      // the pulse length check below needs at least two cycles of reset
      if (RESET_CYCLES < 2 || RESET_CYCLES > 65535) $error("pbc_ctrl_reg: RESET_CYCLES out of range");
   end

   typedef struct packed {
      logic loopback;
      logic one_way;
      logic [1:0] speed;
      logic [15:0] rdata;
      logic rvalid;
   } pbc_main_s;

   pbc_main_s state_q, state_d;
   logic hit;
   logic wr_hit;
   logic soft_busy;
   logic soft_start;
   logic standby;
   logic isolate;
   logic one_way_eff;
   logic [15:0] reg_view;

   // an access to the register index; other indices belong to other blocks
   assign hit = (req_i.addr == PBC_REG_INDEX);
   assign wr_hit = req_i.wr & hit & ~soft_busy;
   assign soft_start = wr_hit & req_i.wdata[PBC_BIT_SOFT_RESET];

   // soft reset timer; its busy phase both drives the PHY reset and reads back as 1
   pbc_reset_pulse #(
      .CYCLES(RESET_CYCLES)
   ) u_pulse (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .start_i(soft_start),
      .busy_o(soft_busy)
   );

   // standby and isolation share one controller so conflicts are judged on one mode
   pbc_mode_ctrl u_mode (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .clear_i(soft_start),
      .wr_i(wr_hit & ~soft_start),
      .standby_wr_i(req_i.wdata[PBC_BIT_STANDBY]),
      .isolate_wr_i(req_i.wdata[PBC_BIT_ISOLATE]),
      .op_state_i(op_state_i),
      .standby_o(standby),
      .isolate_o(isolate),
      .conflict_o(control_conflict_o),
      .normal_req_o(normal_req_o)
   );

   // assemble the read view; fixed bits are constants, not storage
   always_comb begin
      reg_view = '0;
      reg_view[PBC_BIT_SOFT_RESET] = soft_busy;
      reg_view[PBC_BIT_LOOPBACK] = state_q.loopback;
      reg_view[PBC_BIT_SPEED_LSB] = state_q.speed[0];
      reg_view[PBC_BIT_NEG_EN] = PBC_FIX_NEG_EN;
      reg_view[PBC_BIT_STANDBY] = standby;
      reg_view[PBC_BIT_ISOLATE] = isolate;
      reg_view[PBC_BIT_NEG_RESTART] = PBC_FIX_NEG_RESTART;
      reg_view[PBC_BIT_DUPLEX] = PBC_FIX_DUPLEX;
      reg_view[PBC_BIT_COL_TEST] = PBC_FIX_COL_TEST;
      reg_view[PBC_BIT_SPEED_MSB] = state_q.speed[1];
      reg_view[PBC_BIT_ONE_WAY] = state_q.one_way;
   end

   // register next state: writes, soft reset defaults, read capture
   always_comb begin
      state_d = state_q;
      state_d.rvalid = req_i.rd;
      if (req_i.rd) begin
         // unmapped indices read as zero
         state_d.rdata = hit ? reg_view : 16'h0000;
      end
      if (soft_start) begin
         // the whole register returns to defaults with the PHY
         state_d.loopback = PBC_RST_LOOPBACK;
         state_d.one_way = PBC_RST_ONE_WAY;
         state_d.speed = PBC_SPEED_100;
      end else if (wr_hit) begin
         state_d.loopback = req_i.wdata[PBC_BIT_LOOPBACK];
         state_d.one_way = req_i.wdata[PBC_BIT_ONE_WAY];
         // only the supported code is accepted
         if ({req_i.wdata[PBC_BIT_SPEED_MSB], req_i.wdata[PBC_BIT_SPEED_LSB]} == PBC_SPEED_100) begin
            state_d.speed = PBC_SPEED_100;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         state_q <= '{loopback: PBC_RST_LOOPBACK, one_way: PBC_RST_ONE_WAY,
                      speed: PBC_SPEED_100, rdata: 16'h0000, rvalid: 1'b0};
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   // one-way transmit qualified by the fixed negotiation and duplex bits
   assign one_way_eff = state_q.one_way & ~PBC_FIX_NEG_EN & PBC_FIX_DUPLEX;

   // control outputs to the PHY core
   always_comb begin
      ctrl_o.loopback = state_q.loopback;
      ctrl_o.loop_path = state_q.loopback ? loop_path_i : 2'h0;
      ctrl_o.standby = standby;
      ctrl_o.isolate = isolate;
      ctrl_o.tx_enable = link_valid_i | one_way_eff;
   end

   assign rdata_o = state_q.rdata;
   assign rvalid_o = state_q.rvalid & ce_i;
   assign phy_reset_o = soft_busy;

   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_soft_reset_start: assert property (
      (ce_i && soft_start) |=> phy_reset_o)
      else $error("soft reset write did not raise phy reset");

   chk_soft_reset_clears: assert property (
      $fell(phy_reset_o) |-> (reg_view[PBC_BIT_SOFT_RESET] == 1'b0))
      else $error("soft reset bit did not clear");

   chk_neg_bits_zero: assert property (
      (reg_view[PBC_BIT_NEG_EN] == 1'b0) && (reg_view[PBC_BIT_NEG_RESTART] == 1'b0))
      else $error("negotiation bits not zero");

   chk_duplex_fixed: assert property (
      (ce_i && req_i.rd && hit) |=> rdata_o[PBC_BIT_DUPLEX])
      else $error("duplex bit did not read 1");

   chk_col_test_zero: assert property (
      (ce_i && req_i.rd) |=> !rdata_o[PBC_BIT_COL_TEST])
      else $error("collision test bit did not read 0");

   chk_standby_enter: assert property (
      (ce_i && wr_hit && !soft_start && req_i.wdata[PBC_BIT_STANDBY] && !isolate) |=> ctrl_o.standby)
      else $error("standby not entered");

   chk_standby_refused: assert property (
      (ce_i && wr_hit && !soft_start && req_i.wdata[PBC_BIT_STANDBY] && isolate)
      |=> (!ctrl_o.standby && control_conflict_o))
      else $error("standby during isolation not refused");

   chk_normal_request: assert property (
      (ce_i && wr_hit && !soft_start && standby && !req_i.wdata[PBC_BIT_STANDBY])
      |=> (normal_req_o == ($past(op_state_i) == PBC_OP_STATE_NORMAL)))
      else $error("normal mode request wrong");

   chk_isolate_enter: assert property (
      (ce_i && wr_hit && !soft_start && req_i.wdata[PBC_BIT_ISOLATE] && !req_i.wdata[PBC_BIT_STANDBY]
       && !standby) |=> ctrl_o.isolate)
      else $error("isolation not entered");

   chk_isolate_refused: assert property (
      (ce_i && wr_hit && !soft_start && req_i.wdata[PBC_BIT_ISOLATE] && standby)
      |=> (!ctrl_o.isolate && control_conflict_o))
      else $error("isolation during standby not refused");

   chk_modes_exclusive: assert property (
      !(ctrl_o.standby && ctrl_o.isolate))
      else $error("standby and isolation both active");

   chk_speed_fixed: assert property (
      ({reg_view[PBC_BIT_SPEED_MSB], reg_view[PBC_BIT_SPEED_LSB]} == PBC_SPEED_100))
      else $error("speed select left 100 Mbit/s");

   chk_speed_after_reset: assert property (
      $rose(reset_n_i) |-> (state_q.speed == PBC_SPEED_100))
      else $error("speed select not 100 Mbit/s after reset");

   chk_tx_gate: assert property (
      (!link_valid_i && !state_q.one_way) |-> !ctrl_o.tx_enable)
      else $error("transmit enabled without link or one-way");

   chk_one_way_tx: assert property (
      (ce_i && wr_hit && !soft_start && req_i.wdata[PBC_BIT_ONE_WAY]) |=> ctrl_o.tx_enable)
      else $error("one-way transmit not effective");

   chk_loopback_path: assert property (
      (ce_i && wr_hit && !soft_start && !req_i.wdata[PBC_BIT_LOOPBACK])
      |=> (!ctrl_o.loopback && ctrl_o.loop_path == 2'h0))
      else $error("loopback still active after clear");

   chk_reset_length: assert property (
      (ce_i && soft_start) |=> phy_reset_o [*2])
      else $error("soft reset pulse too short");

   cov_soft_reset: cover property (ce_i && soft_start);
   cov_standby_conflict: cover property (control_conflict_o && isolate);
   cov_normal_req: cover property (normal_req_o);
   cov_one_way_no_link: cover property (ctrl_o.tx_enable && !link_valid_i);

endmodule : pbc_ctrl_reg

// ==== sim/pbc_host_model.sv ====
// station management host model for the basic control register
// assumes decoded strobes; drives 1 ns after each rising edge
`timescale 1ns/1ps
module pbc_host_model
   import pbc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rvalid_i,
   input wire logic [15:0] rdata_i,
   output logic ce_o,
   output pbc_req_s req_o
);
   initial begin
      ce_o = 1'b1;
      req_o = '0;
   end

   // strobe held one cycle up to the taking edge; idle data inverted so stale values never pass
   task automatic wr(input logic [4:0] addr, input logic [15:0] data);
      @(posedge core_clk_i);
      #1;
      req_o = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge core_clk_i);
      #1;
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask : wr

   // answer sampled in the cycle after the taking edge
   task automatic rd(input logic [4:0] addr, output logic [15:0] data, output logic ok);
      @(posedge core_clk_i);
      #1;
      req_o = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
      @(posedge core_clk_i);
      #1;
      req_o.rd = 1'b0;
      ok = rvalid_i;
      data = rdata_i;
   endtask : rd

   // loopback is set on its own in one write, with standby, isolation and one-way cleared
   task automatic loopback_on();
      wr(5'h00, 16'h6100);
   endtask : loopback_on
endmodule : pbc_host_model

// ==== sim/pbc_ctrl_reg_tb_top.sv ====
// self-checking bench for the basic control register
// assumes the host model as only register master, shortened soft reset pulse
`timescale 1ns/1ps
module pbc_ctrl_reg_tb_top;
   import pbc_pkg::*;
   localparam int RST_CYC = 2;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce;
   pbc_req_s req;
   logic [15:0] rdata;
   logic rvalid;
   logic [3:0] op_state = 4'h0;
   logic [1:0] loop_path = 2'h0;
   logic link_valid = 1'b0;
   logic phy_reset;
   logic conflict;
   logic normal_req;
   pbc_ctrl_s ctrl;
   int failures = 0;
   int num_checks = 0;

   pbc_host_model H (.core_clk_i(core_clk), .rvalid_i(rvalid), .rdata_i(rdata), .ce_o(ce), .req_o(req));
   pbc_ctrl_reg #(.RESET_CYCLES(RST_CYC)) DUT (.core_clk_i(core_clk), .reset_n_i(reset_n), .ce_i(ce),
      .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .op_state_i(op_state), .loop_path_i(loop_path),
      .link_valid_i(link_valid), .phy_reset_o(phy_reset), .control_conflict_o(conflict),
      .normal_req_o(normal_req), .ctrl_o(ctrl));

   // 25 MHz clock
   initial begin
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // register read with its valid strobe judged as well
   task automatic rdc(input string what, input logic [4:0] addr, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      H.rd(addr, d, ok);
      chk("rvalid", 16'(ok), 16'h0001);
      chk(what, d, exp);
   endtask : rdc

   task automatic t_reset_values();
      rdc("reset value", 5'h00, 16'h2100);
      chk("loopback after reset", 16'(ctrl.loopback), 16'h0000);
      rdc("unmapped read", 5'h01, 16'h0000);
   endtask : t_reset_values

   // every speed code, with the fixed bits written to their wrong values
   task automatic t_speed_fixed();
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         H.wr(5'h00, 16'h1280 | (16'(c[1]) << 6) | (16'(c[0]) << 13));
         rdc("speed and fixed bits", 5'h00, 16'h2100);
      end
   endtask : t_speed_fixed

   task automatic t_standby();
      H.wr(5'h00, 16'h2900);
      chk("standby set", 16'(ctrl.standby), 16'h0001);
      rdc("standby read", 5'h00, 16'h2900);
      H.wr(5'h00, 16'h2D00);
      chk("isolate conflict", 16'(conflict), 16'h0001);
      chk("isolate refused", 16'(ctrl.isolate), 16'h0000);
      @(posedge core_clk);
      #1;
      chk("conflict one cycle", 16'(conflict), 16'h0000);
      H.wr(5'h00, 16'h2100);
      chk("no normal request", 16'(normal_req), 16'h0000);
      chk("standby cleared", 16'(ctrl.standby), 16'h0000);
      H.wr(5'h00, 16'h2900);
      op_state = PBC_OP_STATE_NORMAL;
      H.wr(5'h00, 16'h2100);
      chk("normal request", 16'(normal_req), 16'h0001);
      op_state = 4'h0;
   endtask : t_standby

   task automatic t_isolate();
      H.wr(5'h00, 16'h2500);
      chk("isolate set", 16'(ctrl.isolate), 16'h0001);
      H.wr(5'h00, 16'h2D00);
      chk("standby conflict", 16'(conflict), 16'h0001);
      chk("standby refused", 16'(ctrl.standby), 16'h0000);
      rdc("isolate kept", 5'h00, 16'h2500);
      H.wr(5'h00, 16'h2100);
   endtask : t_isolate

   task automatic t_one_way();
      chk("tx waits link", 16'(ctrl.tx_enable), 16'h0000);
      H.wr(5'h00, 16'h2120);
      chk("tx without link", 16'(ctrl.tx_enable), 16'h0001);
      rdc("one way read", 5'h00, 16'h2120);
      H.wr(5'h00, 16'h2100);
      link_valid = 1'b1;
      #1;
      chk("tx with link", 16'(ctrl.tx_enable), 16'h0001);
      link_valid = 1'b0;
   endtask : t_one_way

   task automatic t_loopback();
      loop_path = 2'h2;
      #1;
      chk("path idle", 16'(ctrl.loop_path), 16'h0000);
      H.loopback_on();
      chk("loopback on", 16'(ctrl.loopback), 16'h0001);
      chk("path passed", 16'(ctrl.loop_path), 16'h0002);
      rdc("loopback read", 5'h00, 16'h6100);
   endtask : t_loopback

   // pulse counted cycle by cycle; writable bits must drop at once
   task automatic t_soft_reset();
      H.wr(5'h00, 16'hE100);
      chk("reset pulse start", 16'(phy_reset), 16'h0001);
      chk("loopback cleared", 16'(ctrl.loopback), 16'h0000);
      repeat (RST_CYC - 1) @(posedge core_clk);
      #1;
      chk("reset pulse held", 16'(phy_reset), 16'h0001);
      @(posedge core_clk);
      #1;
      chk("reset pulse end", 16'(phy_reset), 16'h0000);
      rdc("after soft reset", 5'h00, 16'h2100);
   endtask : t_soft_reset

   task automatic tally_and_finish();
      if (failures == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // run takes well under 200 cycles
   initial begin
      #(40 * 5000);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (8) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      t_reset_values();
      t_speed_fixed();
      t_standby();
      t_isolate();
      t_one_way();
      t_loopback();
      t_soft_reset();
      tally_and_finish();
   end
endmodule : pbc_ctrl_reg_tb_top
